// *** design/baalu_pkg.sv ***
// Package: register map, field layout, opcodes and state types of the byte ALU datapath
package baalu_pkg;
    // ----------------------------------------------------------------
    // Register byte offsets on the Wishbone slave
    // ----------------------------------------------------------------
    localparam logic [4:0] REG_CTRL     = 5'h00; // Extended set enable
    localparam logic [4:0] REG_INSTR    = 5'h04; // Instruction issue (write starts)
    localparam logic [4:0] REG_WREG     = 5'h08; // Working register
    localparam logic [4:0] REG_STATUS   = 5'h0c; // Flags, busy, bad opcode
    localparam logic [4:0] REG_BSR      = 5'h10; // bank_select_register
    localparam logic [4:0] REG_FSR2     = 5'h14; // Indexed literal offset base
    localparam logic [4:0] REG_MEM_ADDR = 5'h18; // Data memory window address
    localparam logic [4:0] REG_MEM_DATA = 5'h1c; // Data memory window data
    // ----------------------------------------------------------------
    // Status field positions
    // ----------------------------------------------------------------
    localparam int ST_C    = 0;
    localparam int ST_DC   = 1;
    localparam int ST_Z    = 2;
    localparam int ST_OV   = 3;
    localparam int ST_N    = 4;
    localparam int ST_BUSY = 8;
    localparam int ST_BAD  = 9;
    // ----------------------------------------------------------------
    // Opcode fields (upper six bits, or eight for the literal form)
    // ----------------------------------------------------------------
    localparam logic [5:0] OPC_ADD_WF   = 6'h09; // 0010 01da
    localparam logic [5:0] OPC_ADDC_WF  = 6'h08; // 0010 00da
    localparam logic [5:0] OPC_AND_WF   = 6'h05; // 0001 01da
    localparam logic [7:0] OPC_AND_LIT  = 8'h0b; // 0000 1011
    localparam logic [7:0] ACCESS_LIMIT = 8'h5f; // Low access range top
    localparam logic [3:0] ACCESS_HIGH  = 4'hf;  // Bank of the upper access range
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0]  WREG_RST = 8'h00;
    localparam logic [4:0]  FLAG_RST = 5'h00;
    localparam logic [3:0]  BSR_RST  = 4'h0;
    localparam logic [11:0] FSR_RST  = 12'h000;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE
    } baalu_phase_type;
    typedef enum logic [1:0] {
        OP_ADD, OP_ADDC, OP_AND_F, OP_AND_L
    } baalu_op_type;
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } baalu_flags_type;
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [4:0]  adr;
        logic [31:0] dat;
    } baalu_wb_req_type;
endpackage

// *** design/baalu_core.sv ***
// Byte ALU datapath: add, add with carry, AND literal, AND file, behind a Wishbone slave
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - 0010 01da: W plus file to destination
// - d=0 writes W, d=1 writes file
// - a=0 access bank, a=1 uses bank select
// - a=0, extended, f<=5Fh: indexed literal offset
// - 0010 00da: W plus file plus carry
// - 0000 1011: W AND literal into W
// - 0001 01da: W AND file to destination
// - ANDs update only N and Z
module baalu_core #(
    parameter int MEM_BYTES = 4096 // Data memory size, twelve address bits
) (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire baalu_pkg::baalu_wb_req_type wb_req,
    output logic [31:0]                     wb_dat_o,
    output logic                            wb_ack_o
);
    import baalu_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [7:0]      mem [MEM_BYTES];          // Data memory file registers
    baalu_phase_type ph_q, ph_d;               // Quarter phase sequencer
    baalu_op_type    op_q, op_d;               // Decoded operation
    logic            to_file_q, to_file_d;     // Destination is the file register
    logic [11:0]     addr_q, addr_d;           // Resolved operand address
    logic [7:0]      opnd_q, opnd_d;           // Second operand
    logic [7:0]      res_q, res_d;             // Processed result
    baalu_flags_type fl_q, fl_d;               // Status flags
    baalu_flags_type fl_new_q, fl_new_d;       // Flags from processing
    logic [15:0]     instr_q, instr_d;         // Issued instruction word
    logic [7:0]      wreg_q, wreg_d;           // Working register
    logic [3:0]      bsr_q, bsr_d;             // bank_select_register
    logic [11:0]     fsr_q, fsr_d;             // Indexed offset base
    logic            ext_q, ext_d;             // Extended set enable
    logic            bad_q, bad_d;             // Sticky bad opcode
    logic [11:0]     maddr_q, maddr_d;         // Window address
    logic            ack_q, ack_d;             // Wishbone acknowledge
    logic [31:0]     rdat_q, rdat_d;           // Read data
    logic            mem_we;                   // Memory write strobe
    logic [11:0]     mem_wa;                   // Memory write address
    logic [7:0]      mem_wd;                   // Memory write data
    logic            bus_hit;                  // Access taken this cycle
    logic            bus_wr;                   // Write taken this cycle
    logic [7:0]      f_field;                  // Instruction file address
    logic [8:0]      sum9;                     // Full add result
    logic [4:0]      sum_lo;                   // Low nibble sum
    logic            cin;                      // Carry into the add

    assign bus_hit = wb_req.cyc && wb_req.stb && !ack_q;
    assign bus_wr  = bus_hit && wb_req.we && wb_req.sel[0];
    assign f_field = instr_q[7:0];
    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ----------------------------------------------------------------
    // Arithmetic
    // ----------------------------------------------------------------
    // Carry enters only for the carry form; plain add ignores the flag
    assign cin    = (op_q == OP_ADDC) ? fl_q.c : 1'b0;
    assign sum9   = {1'b0, wreg_q} + {1'b0, opnd_q} + {8'h00, cin};
    assign sum_lo = {1'b0, wreg_q[3:0]} + {1'b0, opnd_q[3:0]} + {4'h0, cin};

    // ----------------------------------------------------------------
    // Next state of sequencer, datapath and registers
    // ----------------------------------------------------------------
    always_comb begin
        ph_d      = ph_q;
        op_d      = op_q;
        to_file_d = to_file_q;
        addr_d    = addr_q;
        opnd_d    = opnd_q;
        res_d     = res_q;
        fl_d      = fl_q;
        fl_new_d  = fl_new_q;
        instr_d   = instr_q;
        wreg_d    = wreg_q;
        bsr_d     = bsr_q;
        fsr_d     = fsr_q;
        ext_d     = ext_q;
        bad_d     = bad_q;
        maddr_d   = maddr_q;
        mem_we    = 1'b0;
        mem_wa    = maddr_q;
        mem_wd    = wb_req.dat[7:0];
        unique case (ph_q)
            PH_IDLE: begin
                // Issue only when idle; a write while busy is dropped
                if (bus_wr && wb_req.adr == REG_INSTR) begin
                    instr_d = wb_req.dat[15:0];
                    ph_d    = PH_DECODE;
                end
            end
            PH_DECODE: begin
                ph_d      = PH_READ;
                to_file_d = instr_q[9];
                // Bank choice: a=1 bank select, a=0 access bank
                if (instr_q[8]) begin
                    addr_d = {bsr_q, f_field};
                end else if (ext_q && f_field <= ACCESS_LIMIT) begin
                    addr_d = fsr_q + {4'h0, f_field};
                end else if (f_field <= ACCESS_LIMIT) begin
                    addr_d = {4'h0, f_field};
                end else begin
                    addr_d = {ACCESS_HIGH, f_field};
                end
                if (instr_q[15:10] == OPC_ADD_WF) begin
                    op_d = OP_ADD;
                end else if (instr_q[15:10] == OPC_ADDC_WF) begin
                    op_d = OP_ADDC;
                end else if (instr_q[15:10] == OPC_AND_WF) begin
                    op_d = OP_AND_F;
                end else if (instr_q[15:8] == OPC_AND_LIT) begin
                    op_d      = OP_AND_L;
                    to_file_d = 1'b0;
                end else begin
                    // Unknown word: flag it and retire without effect
                    bad_d = 1'b1;
                    ph_d  = PH_IDLE;
                end
            end
            PH_READ: begin
                ph_d   = PH_PROC;
                // Literal form reads the instruction, others read memory
                opnd_d = (op_q == OP_AND_L) ? f_field : mem[addr_q];
            end
            PH_PROC: begin
                ph_d     = PH_WRITE;
                fl_new_d = fl_q;
                if (op_q == OP_ADD || op_q == OP_ADDC) begin
                    res_d       = sum9[7:0];
                    fl_new_d.c  = sum9[8];
                    fl_new_d.dc = sum_lo[4];
                    fl_new_d.ov = (wreg_q[7] == opnd_q[7]) && (sum9[7] != wreg_q[7]);
                end else begin
                    res_d = wreg_q & opnd_q;
                end
                fl_new_d.n = res_d[7];
                fl_new_d.z = (res_d == 8'h00);
            end
            PH_WRITE: begin
                ph_d = PH_IDLE;
                fl_d = fl_new_q;
                if (to_file_q) begin
                    mem_we = 1'b1;
                    mem_wa = addr_q;
                    mem_wd = res_q;
                end else begin
                    wreg_d = res_q;
                end
            end
            default: ph_d = PH_IDLE;
        endcase
        // Software writes to state are ignored while an operation runs
        if (bus_wr && ph_q == PH_IDLE) begin
            unique case (wb_req.adr)
                REG_CTRL:     ext_d   = wb_req.dat[0];
                REG_WREG:     wreg_d  = wb_req.dat[7:0];
                REG_STATUS: begin
                    fl_d  = wb_req.dat[4:0];
                    // Write one to clear the bad opcode flag
                    bad_d = bad_q && !wb_req.dat[ST_BAD];
                end
                REG_BSR:      bsr_d   = wb_req.dat[3:0];
                REG_FSR2:     fsr_d   = wb_req.dat[11:0];
                REG_MEM_ADDR: maddr_d = wb_req.dat[11:0];
                REG_MEM_DATA: mem_we  = 1'b1;
                default:      ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Wishbone answer: one wait state, zero for unmapped reads
    // ----------------------------------------------------------------
    always_comb begin
        ack_d  = bus_hit;
        rdat_d = 32'h0000_0000;
        if (bus_hit && !wb_req.we) begin
            unique case (wb_req.adr)
                REG_CTRL:     rdat_d = {31'h0, ext_q};
                REG_INSTR:    rdat_d = {16'h0000, instr_q};
                REG_WREG:     rdat_d = {24'h00_0000, wreg_q};
                REG_STATUS:   rdat_d = {22'h0, bad_q, ph_q != PH_IDLE, 3'h0, fl_q};
                REG_BSR:      rdat_d = {28'h000_0000, bsr_q};
                REG_FSR2:     rdat_d = {20'h0_0000, fsr_q};
                REG_MEM_ADDR: rdat_d = {20'h0_0000, maddr_q};
                REG_MEM_DATA: rdat_d = {24'h00_0000, mem[maddr_q]};
                default:      rdat_d = 32'h0000_0000;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ph_q      <= PH_IDLE;
            op_q      <= OP_ADD;
            to_file_q <= 1'b0;
            addr_q    <= 12'h000;
            opnd_q    <= 8'h00;
            res_q     <= 8'h00;
            fl_q      <= FLAG_RST;
            fl_new_q  <= FLAG_RST;
            instr_q   <= 16'h0000;
            wreg_q    <= WREG_RST;
            bsr_q     <= BSR_RST;
            fsr_q     <= FSR_RST;
            ext_q     <= 1'b0;
            bad_q     <= 1'b0;
            maddr_q   <= 12'h000;
            ack_q     <= 1'b0;
            rdat_q    <= 32'h0000_0000;
        end else begin
            ph_q      <= ph_d;
            op_q      <= op_d;
            to_file_q <= to_file_d;
            addr_q    <= addr_d;
            opnd_q    <= opnd_d;
            res_q     <= res_d;
            fl_q      <= fl_d;
            fl_new_q  <= fl_new_d;
            instr_q   <= instr_d;
            wreg_q    <= wreg_d;
            bsr_q     <= bsr_d;
            fsr_q     <= fsr_d;
            ext_q     <= ext_d;
            bad_q     <= bad_d;
            maddr_q   <= maddr_d;
            ack_q     <= ack_d;
            rdat_q    <= rdat_d;
        end
    end

    // Memory has no reset; contents are software's to initialise
    always_ff @(posedge core_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_add_sum: assert property (
        ph_q == PH_PROC && op_q == OP_ADD |=> res_q == 8'(wreg_q + opnd_q))
        else $error("add result wrong");
    chk_dest_wreg: assert property (
        ph_q == PH_WRITE && !to_file_q |=> wreg_q == $past(res_q))
        else $error("W destination not written");
    chk_dest_file: assert property (
        ph_q == PH_WRITE && to_file_q
        |-> mem_we && mem_wa == addr_q && mem_wd == res_q ##1 wreg_q == $past(wreg_q))
        else $error("file destination not written");
    chk_bank_sel: assert property (
        ph_q == PH_DECODE && instr_q[8] |=> addr_q == {bsr_q, $past(instr_q[7:0])})
        else $error("bank select address wrong");
    chk_indexed_addr: assert property (
        ph_q == PH_DECODE && !instr_q[8] && ext_q && instr_q[7:0] <= ACCESS_LIMIT
        |=> addr_q == 12'($past(fsr_q) + {4'h0, $past(instr_q[7:0])}))
        else $error("indexed address wrong");
    chk_add_carry: assert property (
        ph_q == PH_PROC && (op_q == OP_ADD || op_q == OP_ADDC) |=> ##1 fl_q.c == $past(sum9[8], 2))
        else $error("carry flag wrong");
    chk_addc_sum: assert property (
        ph_q == PH_PROC && op_q == OP_ADDC |=> res_q == 8'(wreg_q + opnd_q + {7'h0, fl_q.c}))
        else $error("add with carry result wrong");
    chk_and_lit: assert property (
        ph_q == PH_READ && op_q == OP_AND_L |=> opnd_q == instr_q[7:0] ##1 res_q == (wreg_q & opnd_q) ##1 !to_file_q)
        else $error("literal AND wrong");
    chk_and_keep: assert property (
        ph_q == PH_WRITE && (op_q == OP_AND_F || op_q == OP_AND_L)
        |=> fl_q.c == $past(fl_q.c) && fl_q.dc == $past(fl_q.dc) && fl_q.ov == $past(fl_q.ov))
        else $error("AND changed arithmetic flags");
    chk_phase_walk: assert property (
        ph_q == PH_READ |=> ph_q == PH_PROC ##1 ph_q == PH_WRITE ##1 ph_q == PH_IDLE)
        else $error("phase sequence broken");
    // Flags are judged one cycle after the write phase, once they have landed
    chk_and_file: assert property (
        ph_q == PH_PROC && op_q == OP_AND_F |=> res_q == (wreg_q & opnd_q))
        else $error("file AND result wrong");
    chk_add_flags: assert property (
        ph_q == PH_PROC && (op_q == OP_ADD || op_q == OP_ADDC)
        |=> ##1 fl_q.dc == $past(sum_lo[4], 2) && fl_q.n == $past(res_q[7])
            && fl_q.z == ($past(res_q) == 8'h00))
        else $error("add flags wrong");
    chk_and_flags: assert property (
        ph_q == PH_WRITE && (op_q == OP_AND_F || op_q == OP_AND_L)
        |=> fl_q.z == ($past(res_q) == 8'h00) && fl_q.n == $past(res_q[7]))
        else $error("AND flags wrong");
endmodule
`default_nettype wire

// *** tb/baalu_core_tb.sv ***
// Self-checking testbench for the byte ALU datapath behind its Wishbone slave
`timescale 1ns/1ps
`default_nettype none
module baalu_core_tb;
    import baalu_pkg::*;
    // ----------------------------------------------------------------
    // Signals and counters
    // ----------------------------------------------------------------
    logic              core_clk;    // 200 MHz core clock
    logic              rstn;        // Synchronous reset, active low
    baalu_wb_req_type  wb_req;      // Bus request driven by the bench
    logic [31:0]       wb_dat_o;    // Read data from the slave
    logic              wb_ack_o;    // Acknowledge from the slave
    int                failures;    // Mismatches seen
    int                comparisons; // Comparisons made

    baalu_core dut (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wb_req   (wb_req),
        .wb_dat_o (wb_dat_o),
        .wb_ack_o (wb_ack_o)
    );

    // ----------------------------------------------------------------
    // Clock and watchdog
    // ----------------------------------------------------------------
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // About 70 bus cycles are expected; this leaves a wide margin
    initial begin
        #20000;
        failures++;
        $display("ERROR at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One classic cycle; waits for ack without assuming a latency
    task automatic wb_cycle(input logic we, input logic [4:0] adr, input logic [31:0] dat,
                            output logic [31:0] rd);
        @(posedge core_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        // Only the watchdog ends a wait that never sees ack
        do begin
            @(posedge core_clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_req <= '0;
    endtask

    task automatic wr(input logic [4:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_cycle(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(input logic [4:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_cycle(1'b0, adr, 32'h0000_0000, d);
        check(d, exp, "register read");
    endtask

    task automatic mem_set(input logic [11:0] a, input logic [7:0] v);
        wr(REG_MEM_ADDR, {20'h0_0000, a});
        wr(REG_MEM_DATA, {24'h00_0000, v});
    endtask

    task automatic mem_chk(input logic [11:0] a, input logic [7:0] v);
        wr(REG_MEM_ADDR, {20'h0_0000, a});
        rd_chk(REG_MEM_DATA, {24'h00_0000, v});
    endtask

    // Issue an instruction, see it busy, then wait until it retires
    task automatic exec(input logic [15:0] instr);
        logic [31:0] d;
        int n;
        wr(REG_INSTR, {16'h0000, instr});
        wb_cycle(1'b0, REG_STATUS, 32'h0000_0000, d);
        check({31'h0000_0000, d[ST_BUSY]}, 32'h0000_0001, "busy after issue");
        n = 0;
        while (d[ST_BUSY] !== 1'b0 && n < 8) begin
            wb_cycle(1'b0, REG_STATUS, 32'h0000_0000, d);
            n++;
        end
        check({31'h0000_0000, d[ST_BUSY]}, 32'h0000_0000, "busy cleared");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    // Reset values and an unmapped offset
    task automatic t_reset;
        rd_chk(REG_WREG, 32'h0000_0000);
        rd_chk(REG_STATUS, 32'h0000_0000);
        rd_chk(REG_BSR, 32'h0000_0000);
        rd_chk(5'h02, 32'h0000_0000);
        $display("test reset done");
    endtask

    // Add into W, access bank upper range, file left alone
    task automatic t_add_w;
        mem_set(12'hfc5, 8'hc2);
        wr(REG_WREG, 32'h0000_0017);
        exec({OPC_ADD_WF, 1'b0, 1'b0, 8'hc5});
        rd_chk(REG_WREG, 32'h0000_00d9);
        rd_chk(REG_STATUS, 32'h0000_0010);
        mem_chk(12'hfc5, 8'hc2);
        $display("test add to W done");
    endtask

    // Add with carry into file through the bank select register
    task automatic t_addc_file;
        wr(REG_BSR, 32'h0000_0003);
        mem_set(12'h320, 8'h02);
        wr(REG_WREG, 32'h0000_004d);
        wr(REG_STATUS, 32'h0000_0001);
        exec({OPC_ADDC_WF, 1'b1, 1'b1, 8'h20});
        mem_chk(12'h320, 8'h50);
        rd_chk(REG_WREG, 32'h0000_004d);
        rd_chk(REG_STATUS, 32'h0000_0002);
        $display("test add with carry done");
    endtask

    // Signed overflow with carry out and a zero result, low access range
    task automatic t_add_ovf;
        mem_set(12'h010, 8'h80);
        wr(REG_WREG, 32'h0000_0080);
        exec({OPC_ADD_WF, 1'b1, 1'b0, 8'h10});
        mem_chk(12'h010, 8'h00);
        rd_chk(REG_STATUS, 32'h0000_000d);
        $display("test add overflow done");
    endtask

    // AND literal twice: nonzero then zero; C, DC and OV must survive
    task automatic t_and_lit;
        wr(REG_STATUS, 32'h0000_001f);
        wr(REG_WREG, 32'h0000_00a3);
        exec({OPC_AND_LIT, 8'h5f});
        rd_chk(REG_WREG, 32'h0000_0003);
        rd_chk(REG_STATUS, 32'h0000_000b);
        wr(REG_WREG, 32'h0000_00a3);
        exec({OPC_AND_LIT, 8'h5c});
        rd_chk(REG_WREG, 32'h0000_0000);
        rd_chk(REG_STATUS, 32'h0000_000f);
        $display("test AND literal done");
    endtask

    // AND with file in indexed literal offset mode, result back to file
    task automatic t_and_file_ext;
        wr(REG_CTRL, 32'h0000_0001);
        wr(REG_FSR2, 32'h0000_0200);
        mem_set(12'h210, 8'hc2);
        wr(REG_WREG, 32'h0000_0017);
        wr(REG_STATUS, 32'h0000_0014);
        exec({OPC_AND_WF, 1'b1, 1'b0, 8'h10});
        mem_chk(12'h210, 8'h02);
        rd_chk(REG_STATUS, 32'h0000_0000);
        // Above 5Fh the access bank upper range holds even in extended mode
        exec({OPC_AND_WF, 1'b0, 1'b0, 8'hc5});
        rd_chk(REG_WREG, 32'h0000_0002);
        wr(REG_CTRL, 32'h0000_0000);
        $display("test AND file indexed done");
    endtask

    // Unknown opcode flags itself and is cleared by writing one
    task automatic t_bad_op;
        // Retires in decode, so busy is already low at the first status read
        wr(REG_INSTR, 32'h0000_ffff);
        rd_chk(REG_STATUS, 32'h0000_0200);
        rd_chk(REG_INSTR, 32'h0000_ffff);
        wr(REG_STATUS, 32'h0000_0200);
        rd_chk(REG_STATUS, 32'h0000_0000);
        $display("test bad opcode done");
    endtask

    // ----------------------------------------------------------------
    // Closing and main sequence
    // ----------------------------------------------------------------
    task automatic tally_and_finish;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        failures = 0;
        comparisons = 0;
        wb_req = '0;
        rstn = 1'b0;
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        t_reset();
        t_add_w();
        t_addc_file();
        t_add_ovf();
        t_and_lit();
        t_and_file_ext();
        t_bad_op();
        tally_and_finish();
    end
endmodule
`default_nettype wire
